// >>> hdl/rrsd_pkg.sv
/*
  Constants for the return / rotate / literal-subtract / halt decoder.
  Assumes a 14-bit instruction word and an 8-bit data path.
*/
package rrsd_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  // ----------------------------------------------------------------
  // Opcodes and masks
  // ----------------------------------------------------------------
  localparam logic [13:0] OPC_RETURN = 14'h0008;
  localparam logic [13:0] OPC_HALT = 14'h0063;
  localparam logic [13:0] MASK_FILE_OP = 14'h3F00;
  localparam logic [13:0] OPC_ROT_RIGHT = 14'h0C00;
  localparam logic [13:0] MASK_LIT_SUB = 14'h3E00;
  localparam logic [13:0] OPC_LIT_SUB = 14'h3C00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DEST_BIT = 7;
  localparam int FADDR_MSB = 6;
  localparam int LIT_MSB = 7;
  localparam int HALF_BIT = 4;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [7:0] WDT_RST = 8'h00;
  localparam int RETURN_CYCLES = 2;
endpackage : rrsd_pkg

// >>> hdl/rrsd_alu.sv
/*
  Combinational datapath: right rotate through carry and literal minus
  accumulator with carry, half-carry and zero results.
  Assumes operands are stable while the decoder samples the outputs.
*/
module rrsd_alu
  import rrsd_pkg::*;
(
  // Operands
  input wire logic [DATA_W-1:0] file_in,
  input wire logic [DATA_W-1:0] acc_in,
  input wire logic [DATA_W-1:0] lit_in,
  input wire logic carry_in,
  // Rotate results
  output logic [DATA_W-1:0] rot_out,
  output logic rot_carry_out,
  // Subtract results
  output logic [DATA_W-1:0] sub_out,
  output logic sub_carry_out,
  output logic sub_half_out,
  output logic sub_zero_out
);
  logic [DATA_W:0] diff;
  logic [HALF_BIT:0] low_diff;

  always_comb begin
    rot_out = {carry_in, file_in[DATA_W-1:1]};
    rot_carry_out = file_in[0];
    // Two's complement: k + ~W + 1
    diff = {1'b0, lit_in} + {1'b0, ~acc_in} + 9'h001;
    low_diff = {1'b0, lit_in[HALF_BIT-1:0]} + {1'b0, ~acc_in[HALF_BIT-1:0]}
      + 5'h01;
    sub_out = diff[DATA_W-1:0];
    sub_carry_out = diff[DATA_W];
    sub_half_out = low_diff[HALF_BIT];
    sub_zero_out = (diff[DATA_W-1:0] == 8'h00);
  end
endmodule : rrsd_alu

// >>> hdl/rrsd_decode.sv
/*
  Decode and execute for subroutine return, rotate right through carry,
  literal minus accumulator and halt.
  Assumes the instruction, file read data and stack top are presented
  with insn_valid_in; file writes and stack pop are done by the core.
*/
// Overview of operation
// - Return pops stack, loads stack top into PC, flags kept, two cycles.
// - Rotate right: old carry to bit 7, old bit 0 to carry.
// - Rotate destination 0 writes accumulator, 1 writes file register.
// - Acc gets literal minus acc, sets carry, half-carry, zero, one cycle.
// - Subtract carry set when result non-negative, cleared when negative.
// - Halt clears powerdown, sets timeout, clears watchdog and prescaler.
module rrsd_decode
  import rrsd_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Instruction issue
  input wire logic insn_valid_in,
  input wire logic [INSN_W-1:0] insn_in,
  input wire logic [DATA_W-1:0] file_rdata_in,
  input wire logic [PC_W-1:0] stack_top_in,
  input wire logic wake_in,
  // Core state
  output logic busy_out,
  output logic [PC_W-1:0] pc_out,
  output logic pc_load_out,
  output logic stack_pop_out,
  output logic [DATA_W-1:0] acc_out,
  output logic carry_flag_out,
  output logic half_carry_flag_out,
  output logic zero_flag_out,
  output logic powerdown_flag_out,
  output logic timeout_flag_out,
  // File register write
  output logic file_we_out,
  output logic [FADDR_W-1:0] file_addr_out,
  output logic [DATA_W-1:0] file_wdata_out,
  // Watchdog and oscillator
  output logic wdt_clear_out,
  output logic sleep_out
);
  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic match(input logic [INSN_W-1:0] w,
                                 input logic [INSN_W-1:0] m,
                                 input logic [INSN_W-1:0] v);
    match = ((w & m) == v);
  endfunction : match

  typedef enum logic [2:0] {
    RRSD_RUN = 3'b001,
    RRSD_RET2 = 3'b010,
    RRSD_SLEEP = 3'b100
  } rrsd_state_t;
  rrsd_state_t state_q;

  logic issue;
  logic is_ret;
  logic is_rot;
  logic is_sub;
  logic is_halt;
  logic dest_file;
  logic [FADDR_W-1:0] faddr;
  logic [DATA_W-1:0] lit;
  assign issue = insn_valid_in && (state_q == RRSD_RUN);
  assign is_ret = issue && match(insn_in, {INSN_W{1'b1}}, OPC_RETURN);
  assign is_halt = issue && match(insn_in, {INSN_W{1'b1}}, OPC_HALT);
  assign is_rot = issue && match(insn_in, MASK_FILE_OP, OPC_ROT_RIGHT);
  assign is_sub = issue && match(insn_in, MASK_LIT_SUB, OPC_LIT_SUB);
  assign dest_file = insn_in[DEST_BIT];
  assign faddr = insn_in[FADDR_MSB:0];
  assign lit = insn_in[LIT_MSB:0];

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rot_val;
  logic rot_c;
  logic [DATA_W-1:0] sub_val;
  logic sub_c;
  logic sub_hc;
  logic sub_z;
  rrsd_alu u_alu (
    .file_in(file_rdata_in),
    .acc_in(acc_out),
    .lit_in(lit),
    .carry_in(carry_flag_out),
    .rot_out(rot_val),
    .rot_carry_out(rot_c),
    .sub_out(sub_val),
    .sub_carry_out(sub_c),
    .sub_half_out(sub_hc),
    .sub_zero_out(sub_z)
  );

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RRSD_RUN;
    end else begin
      case (state_q)
        RRSD_RUN: begin
          if (is_ret) begin
            state_q <= RRSD_RET2;
          end else if (is_halt) begin
            state_q <= RRSD_SLEEP;
          end
        end
        RRSD_RET2: state_q <= RRSD_RUN;
        RRSD_SLEEP: begin
          if (wake_in) begin
            state_q <= RRSD_RUN;
          end
        end
        default: state_q <= RRSD_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      busy_out <= 1'b0;
      sleep_out <= 1'b0;
    end else begin
      busy_out <= is_ret || is_halt || (state_q == RRSD_SLEEP && !wake_in);
      sleep_out <= is_halt || (state_q == RRSD_SLEEP && !wake_in);
    end
  end

  // ----------------------------------------------------------------
  // Program counter and stack
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      pc_out <= PC_RST;
      pc_load_out <= 1'b0;
      stack_pop_out <= 1'b0;
    end else begin
      pc_load_out <= is_ret;
      stack_pop_out <= is_ret;
      if (is_ret) begin
        pc_out <= stack_top_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and file write
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      acc_out <= ACC_RST;
      file_we_out <= 1'b0;
      file_addr_out <= '0;
      file_wdata_out <= '0;
    end else begin
      file_we_out <= is_rot && dest_file;
      if (is_rot) begin
        file_addr_out <= faddr;
        file_wdata_out <= rot_val;
        if (!dest_file) begin
          acc_out <= rot_val;
        end
      end else if (is_sub) begin
        acc_out <= sub_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      carry_flag_out <= 1'b0;
      half_carry_flag_out <= 1'b0;
      zero_flag_out <= 1'b0;
    end else begin
      if (is_rot) begin
        carry_flag_out <= rot_c;
      end else if (is_sub) begin
        carry_flag_out <= sub_c;
        half_carry_flag_out <= sub_hc;
        zero_flag_out <= sub_z;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      powerdown_flag_out <= 1'b1;
      timeout_flag_out <= 1'b1;
      wdt_clear_out <= 1'b0;
    end else begin
      wdt_clear_out <= is_halt;
      if (is_halt) begin
        powerdown_flag_out <= 1'b0;
        timeout_flag_out <= 1'b1;
      end
    end
  end
endmodule : rrsd_decode

// >>> verif/rrsd_decode_chk.sv
/*
  Port-level checker for rrsd_decode.
  Assumes it is bound to the decoder and sees its ports only.
*/
module rrsd_decode_chk
  import rrsd_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Instruction issue
  input wire logic insn_valid_in,
  input wire logic [INSN_W-1:0] insn_in,
  input wire logic [DATA_W-1:0] file_rdata_in,
  input wire logic [PC_W-1:0] stack_top_in,
  input wire logic wake_in,
  // Core state
  input wire logic busy_out,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic pc_load_out,
  input wire logic stack_pop_out,
  input wire logic [DATA_W-1:0] acc_out,
  input wire logic carry_flag_out,
  input wire logic half_carry_flag_out,
  input wire logic zero_flag_out,
  input wire logic powerdown_flag_out,
  input wire logic timeout_flag_out,
  // File register write
  input wire logic file_we_out,
  input wire logic [FADDR_W-1:0] file_addr_out,
  input wire logic [DATA_W-1:0] file_wdata_out,
  // Watchdog and oscillator
  input wire logic wdt_clear_out,
  input wire logic sleep_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  logic take, rot, sub;
  assign take = insn_valid_in && !busy_out;
  assign rot = take && (insn_in & MASK_FILE_OP) == OPC_ROT_RIGHT;
  assign sub = take && (insn_in & MASK_LIT_SUB) == OPC_LIT_SUB;
  a_ret_pc_load: assert property (
    take && insn_in == OPC_RETURN |=> pc_load_out && stack_pop_out &&
    busy_out && pc_out == $past(stack_top_in)) else $error("bad return");
  a_ret_flags_kept: assert property (
    take && insn_in == OPC_RETURN |=> $stable(carry_flag_out) &&
    $stable(half_carry_flag_out) && $stable(zero_flag_out))
    else $error("flags moved on return");
  a_ret_dead_cycle: assert property (
    pc_load_out |=> !pc_load_out && !busy_out) else $error("bad return end");
  a_rot_carry_out: assert property (
    rot |=> carry_flag_out == $past(file_rdata_in[0]))
    else $error("bad rotate carry");
  a_rot_to_file: assert property (
    rot && insn_in[DEST_BIT] |=> file_we_out &&
    file_addr_out == $past(insn_in[FADDR_MSB:0]) && file_wdata_out ==
    {$past(carry_flag_out), $past(file_rdata_in[7:1])})
    else $error("bad rotate to file");
  a_rot_to_acc: assert property (
    rot && !insn_in[DEST_BIT] |=> !file_we_out && acc_out ==
    {$past(carry_flag_out), $past(file_rdata_in[7:1])})
    else $error("bad rotate to acc");
  a_sub_result: assert property (
    sub |=> acc_out == $past(insn_in[7:0]) - $past(acc_out) &&
    zero_flag_out == ($past(insn_in[7:0]) == $past(acc_out)))
    else $error("bad subtract");
  a_sub_half_carry: assert property (
    sub |=> half_carry_flag_out ==
    ($past(insn_in[3:0]) >= $past(acc_out[3:0])))
    else $error("bad subtract half carry");
  a_sub_borrow: assert property (
    sub |=> carry_flag_out == ($past(insn_in[7:0]) >= $past(acc_out)))
    else $error("bad subtract carry");
  a_halt_entry: assert property (
    take && insn_in == OPC_HALT |=> sleep_out && busy_out && wdt_clear_out
    && !powerdown_flag_out && timeout_flag_out) else $error("bad halt");
  a_sleep_hold: assert property (
    sleep_out && !wake_in |=> sleep_out) else $error("left sleep early");
  c_return: cover property (pc_load_out);
  c_rot_file: cover property (rot && insn_in[DEST_BIT]);
  c_wake: cover property (sleep_out && wake_in);
endmodule : rrsd_decode_chk

bind rrsd_decode rrsd_decode_chk u_chk (.*);

// >>> verif/rrsd_decode_tb.sv
/*
  Self-checking bench for rrsd_decode.
  Assumes the checker is bound from its own file.
*/
module rrsd_decode_tb
  import rrsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in = 1'b0, rst_n_in = 1'b0, insn_valid_in = 1'b0, wake_in = 1'b0;
  logic [INSN_W-1:0] insn_in = 14'h0000;
  logic [DATA_W-1:0] file_rdata_in = 8'h00, acc_out, file_wdata_out;
  logic [PC_W-1:0] stack_top_in = 13'h0000, pc_out;
  logic busy_out, pc_load_out, stack_pop_out, carry_flag_out, zero_flag_out;
  logic half_carry_flag_out, powerdown_flag_out, timeout_flag_out;
  logic file_we_out, wdt_clear_out, sleep_out;
  logic [FADDR_W-1:0] file_addr_out;
  int err_total = 0, compares = 0;
  rrsd_decode uut (.*);
  always #2 mclk_in = ~mclk_in;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input logic [INSN_W-1:0] insn, input logic [7:0] fd);
    insn_in = insn;
    file_rdata_in = fd;
    insn_valid_in = 1'b1;
    @(posedge mclk_in);
    #1;
  endtask : op
  task automatic idle(input int n);
    insn_valid_in = 1'b0;
    repeat (n) begin
      @(posedge mclk_in);
      #1;
    end
  endtask : idle
  task automatic test_sub;
    op(OPC_LIT_SUB | 14'h0002, 8'h00);
    chk({acc_out, carry_flag_out, half_carry_flag_out, zero_flag_out},
      {8'h02, 3'h6});
    op(OPC_LIT_SUB | 14'h0001, 8'h00);
    chk({acc_out, carry_flag_out, half_carry_flag_out, zero_flag_out},
      {8'hFF, 3'h0});
    op(14'h3DFF, 8'h00);
    chk({acc_out, carry_flag_out, half_carry_flag_out, zero_flag_out},
      {8'h00, 3'h7});
  endtask : test_sub
  task automatic test_rot;
    op(OPC_ROT_RIGHT | 14'h0012, 8'hE6);
    chk({acc_out, carry_flag_out, file_we_out}, {8'hF3, 2'h0});
    op(OPC_ROT_RIGHT | 14'h00D5, 8'h01);
    chk({file_we_out, file_addr_out, file_wdata_out, carry_flag_out, acc_out},
      {1'b1, 7'h55, 8'h00, 1'b1, 8'hF3});
    op(OPC_ROT_RIGHT | 14'h0080, 8'h80);
    chk({file_we_out, file_addr_out, file_wdata_out, carry_flag_out},
      {1'b1, 7'h00, 8'hC0, 1'b0});
  endtask : test_rot
  task automatic test_ret;
    stack_top_in = 13'h1ABC;
    op(OPC_RETURN, 8'h00);
    chk({pc_out, pc_load_out, stack_pop_out, busy_out, carry_flag_out,
      zero_flag_out}, {13'h1ABC, 3'h7, 2'h1});
    // Second cycle of the return refuses this one
    op(OPC_LIT_SUB | 14'h0005, 8'h00);
    chk({pc_load_out, stack_pop_out, busy_out, acc_out},
      {3'h0, 8'hF3});
    idle(1);
  endtask : test_ret
  task automatic test_halt;
    int n;
    op(OPC_HALT, 8'h00);
    chk({sleep_out, busy_out, wdt_clear_out, powerdown_flag_out,
      timeout_flag_out}, 5'h1D);
    op(OPC_LIT_SUB | 14'h0009, 8'h00);
    chk({sleep_out, wdt_clear_out, acc_out}, {2'h2, 8'hF3});
    insn_valid_in = 1'b0;
    wake_in = 1'b1;
    for (n = 0; n < 8 && sleep_out === 1'b1; n++) begin
      @(posedge mclk_in);
      #1;
    end
    wake_in = 1'b0;
    chk({sleep_out, busy_out}, 2'h0);
    if (sleep_out !== 1'b0) begin
      err_total++;
      $display("unexpected at %0t: no wake from sleep", $time);
      tally_and_finish();
    end
    op(OPC_LIT_SUB | 14'h00F3, 8'h00);
    chk({acc_out, zero_flag_out}, {8'h00, 1'b1});
    idle(1);
  endtask : test_halt
  task automatic test_reset;
    rst_n_in = 1'b0;
    idle(2);
    rst_n_in = 1'b1;
    idle(2);
    chk({powerdown_flag_out, timeout_flag_out, acc_out, pc_out},
      {2'h3, ACC_RST, PC_RST});
    chk({busy_out, sleep_out, carry_flag_out, half_carry_flag_out,
      zero_flag_out, pc_load_out, file_we_out}, 7'h00);
    op(OPC_LIT_SUB | 14'h0004, 8'h00);
    chk({acc_out, carry_flag_out}, {8'h04, 1'b1});
    idle(1);
  endtask : test_reset
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (2) @(posedge mclk_in);
    #1;
    rst_n_in = 1'b1;
    idle(2);
    test_sub();
    test_rot();
    test_ret();
    test_halt();
    test_reset();
    tally_and_finish();
  end
  initial begin
    #100000;
    err_total++;
    $display("unexpected at %0t: run timed out", $time);
    tally_and_finish();
  end
endmodule : rrsd_decode_tb
